// [rtl/pdwam_pkg.sv]
/*
  Shared constants and types of the power-down and wake-up activity monitor:
  port addresses, bit positions, reset values and timing counts.
  Assumes a 100 MHz core clock and 12-bit host I/O addresses.
*/
package pdwam_pkg;

  localparam logic [11:0] PORT_BASE      = 12'h220;
  localparam logic [11:0] PORT_BLOCK_MSK = 12'hFF0;
  localparam logic [11:0] PORT_PAIR_MSK  = 12'hFFE;
  localparam logic [11:0] PORT_STATUS    = 12'h226;
  localparam logic [11:0] PORT_PWR_MGMT  = 12'h227;
  localparam logic [11:0] PORT_CODEC     = 12'h222;
  localparam logic [11:0] PORT_SYNTH     = 12'h228;
  localparam logic [11:0] PORT_DSP_READ  = 12'h22A;
  localparam logic [11:0] PORT_DSP_CMD   = 12'h22C;
  localparam logic [11:0] PORT_DSP_ACK   = 12'h22E;
  localparam logic [11:0] PORT_LEGACY_FM = 12'h388;
  localparam logic [11:0] PORT_MUSIC_DEF = 12'h330;

  // status port bit positions
  localparam int ST_SW_RESET   = 0;
  localparam int ST_FIFO_RESET = 1;
  localparam int ST_MIDI_MODE  = 2;
  localparam int ST_POWERED_UP = 3;
  localparam int ST_SERIAL_ACT = 4;
  localparam int ST_ACT_LSB    = 5;

  // power management port bit positions
  localparam int PM_GENERAL_OUTPUT_ZERO       = 0;
  localparam int PM_GENERAL_OUTPUT_ONE       = 1;
  localparam int PM_PD_REQUEST = 2;
  localparam int PM_ANALOG_ON  = 3;
  localparam int PM_SYNTH_RST  = 5;
  localparam int PM_SUSPEND    = 7;

  localparam logic [7:0] PM_WRITE_MSK = 8'hAF;
  localparam logic [7:0] PM_RESET     = 8'h02;
  localparam logic [1:0] ST_RESET     = 2'h0;
  localparam logic [2:0] ACT_RESET    = 3'h7;

  localparam int CLK_HZ          = 100_000_000;
  localparam int ANALOG_HOLD_MS  = 48;
  localparam int ANALOG_HOLD_CYC = ANALOG_HOLD_MS * (CLK_HZ / 1000);
  localparam int IDLE_UNIT_S     = 8;
  localparam int IDLE_UNIT_CYC   = IDLE_UNIT_S * CLK_HZ;

  typedef enum logic [1:0] {PWR_FULL, PWR_PARTIAL, PWR_OFF} pdwam_pwr_t;

endpackage

// [rtl/pdwam_monitor.sv]
/*
  Power-down, wake-up and activity monitor: power state machine, status port,
  power management port, activity flags, analog output hold-off and the
  freezing of request outputs while powered down.
  Assumes host strobes, address and data arrive asynchronously on pins and
  stay stable for several clocks; the core request lines and processor
  status inputs come from logic on CLK.
*/
// Notes on behaviour
// - partial down: analog and oscillator on, synth muted
// - full down stops oscillator and analog power
// - analog outputs held off 48 ms after full down
// - volume up, volume down or mute button wakes the device
// - access to own ports except 226H/227H wakes
// - DMA cycles wake the device
// - hardware or software reset returns full power
// - status bits 0,1 are reset controls, read back
// - status bit 2 shows MIDI serial monitoring
// - status bit 3 low while digital powered down
// - status bit 4 shows serial or external synth
// - status read sets all three activity flags
// - flag 0 cleared by DMA, codec ports, status writes, 22AH reads and 22CH writes
// - flag 1 cleared by reads of 22CH, 22EH
// - flag 2 cleared by synth and music ports
// - request outputs frozen while powered down
// - keeper replaces pulldown on inputs while down
// - general outputs keep programmed levels when down
// - self-timed idle period triggers power-down
// - rising power-down request bit requests power-down
module pdwam_monitor
  import pdwam_pkg::*;
#(
  parameter int          HOLD_CYCLES = pdwam_pkg::ANALOG_HOLD_CYC,
  parameter int          UNIT_CYCLES = pdwam_pkg::IDLE_UNIT_CYC,
  parameter logic [11:0] MUSIC_BASE  = pdwam_pkg::PORT_MUSIC_DEF
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [11:0] IO_ADDR,
  input  wire logic        IO_READ_N,
  input  wire logic        IO_WRITE_N,
  input  wire logic [7:0]  IO_DATA_IN,
  output logic      [7:0]  IO_DATA_OUT,
  output logic             IO_DATA_OE,
  input  wire logic        DMA_ACK_N,
  input  wire logic        VOLUME_UP_BUTTON_N,
  input  wire logic        VOLUME_DOWN_BUTTON_N,
  input  wire logic        MUTE_BUTTON_N,
  input  wire logic        SERIAL_DSP_ENABLE_IN,
  input  wire logic        MIXER_SERIAL_EN,
  input  wire logic        EXT_SYNTH_ACTIVE,
  input  wire logic        MIDI_CMD_ACTIVE,
  input  wire logic        CMD_IDLE,
  input  wire logic [7:0]  IDLE_UNITS,
  input  wire logic        CORE_DMA_REQ,
  input  wire logic        CORE_IRQ,
  output logic             DMA_REQUEST_OUT,
  output logic             INTERRUPT_REQUEST_OUT,
  output logic             GENERAL_OUTPUT_ZERO,
  output logic             GENERAL_OUTPUT_ONE,
  output logic             SOFT_RESET_OUT,
  output logic             FIFO_RESET_OUT,
  output logic             SYNTH_RESET_OUT,
  output logic             SUSPEND_REQ_OUT,
  output logic             OSCILLATOR_RUN,
  output logic             ANALOG_POWER_ON,
  output logic             DIGITAL_POWER_ON,
  output logic             SYNTH_DAC_MUTE,
  output logic             ANALOG_LINE_OUT_EN,
  output logic             PIN_KEEPER_EN,
  output logic             PIN_PULLDOWN_EN,
  output pdwam_pkg::pdwam_pwr_t POWER_STATE
);
  import pdwam_pkg::*;

  // pin synchronisers; stage one feeds stage two only
  logic [11:0] addr_m_q, addr_q;
  logic [7:0]  data_m_q, data_q;
  logic [5:0]  pin_m_q,  pin_q;
  logic [1:0]  strb_q;
  logic        dack_q;
  logic [5:0]  pin_raw;

  assign pin_raw = {SERIAL_DSP_ENABLE_IN, MUTE_BUTTON_N, VOLUME_DOWN_BUTTON_N,
                    VOLUME_UP_BUTTON_N, IO_WRITE_N, IO_READ_N};

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      addr_m_q <= 12'h000;
      addr_q   <= 12'h000;
      data_m_q <= 8'h00;
      data_q   <= 8'h00;
      pin_m_q  <= 6'h3F;
      pin_q    <= 6'h3F;
    end else begin
      addr_m_q <= IO_ADDR;
      addr_q   <= addr_m_q;
      data_m_q <= IO_DATA_IN;
      data_q   <= data_m_q;
      pin_m_q  <= {pin_raw[5:2], pin_raw[1:0]};
      pin_q    <= pin_m_q;
    end
  end

  logic dack_m_q, dack_s_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dack_m_q <= 1'b1;
      dack_s_q <= 1'b1;
      dack_q   <= 1'b1;
      strb_q   <= 2'h3;
    end else begin
      dack_m_q <= DMA_ACK_N;
      dack_s_q <= dack_m_q;
      dack_q   <= dack_s_q;
      strb_q   <= pin_q[1:0];
    end
  end

  // bus event decode on the leading edge of each strobe
  logic rd_evt, wr_evt, acc_evt, dma_evt, vol_low, se_pin;
  logic in_block, in_fm, in_music, in_dev, is_status, is_pm;

  assign rd_evt    = strb_q[0] & ~pin_q[0];
  assign wr_evt    = strb_q[1] & ~pin_q[1];
  assign acc_evt   = rd_evt | wr_evt;
  assign dma_evt   = dack_q & ~dack_s_q;
  assign vol_low   = ~&pin_q[4:2];
  assign se_pin    = pin_q[5];
  assign in_block  = (addr_q & PORT_BLOCK_MSK) == PORT_BASE;
  assign in_fm     = (addr_q & PORT_PAIR_MSK) == PORT_LEGACY_FM;
  assign in_music  = (addr_q & PORT_PAIR_MSK) == MUSIC_BASE;
  assign in_dev    = in_block | in_fm | in_music;
  assign is_status = addr_q == PORT_STATUS;
  assign is_pm     = addr_q == PORT_PWR_MGMT;

  // status port controls and power management port
  logic [1:0] st_q;
  logic [7:0] pm_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= ST_RESET;
      pm_q <= PM_RESET;
    end else begin
      if (wr_evt && is_status) begin
        st_q <= data_q[ST_FIFO_RESET:ST_SW_RESET];
      end
      if (wr_evt && is_pm) begin
        pm_q <= data_q & PM_WRITE_MSK;
      end
    end
  end

  logic pd_prev_q, sw_prev_q;
  logic pd_rise, sw_rise;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pd_prev_q <= 1'b0;
      sw_prev_q <= 1'b0;
    end else begin
      pd_prev_q <= pm_q[PM_PD_REQUEST];
      sw_prev_q <= st_q[ST_SW_RESET];
    end
  end

  assign pd_rise = pm_q[PM_PD_REQUEST] & ~pd_prev_q;
  assign sw_rise = st_q[ST_SW_RESET] & ~sw_prev_q;

  // self-timed power-down: idle time counts only between commands
  pdwam_pwr_t  pwr_q, pwr_d;
  logic [29:0] unit_q;
  logic [7:0]  units_q;
  logic        idle_expire;

  assign idle_expire = (IDLE_UNITS != 8'h00) && (units_q == IDLE_UNITS);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      unit_q  <= 30'h0;
      units_q <= 8'h00;
    end else if (pwr_q != PWR_FULL || acc_evt || dma_evt || !CMD_IDLE || idle_expire) begin
      unit_q  <= 30'h0;
      units_q <= 8'h00;
    end else if (unit_q == 30'(UNIT_CYCLES - 1)) begin
      unit_q  <= 30'h0;
      units_q <= units_q + 8'h01;
    end else begin
      unit_q  <= unit_q + 30'h1;
    end
  end

  // power state machine; wake-up wins over a request in the same cycle
  logic       wake, dev_wake, aso;

  assign aso      = pm_q[PM_ANALOG_ON];
  assign dev_wake = acc_evt & in_dev & ~is_status & ~is_pm;
  assign wake     = dev_wake | dma_evt | vol_low | sw_rise;

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      PWR_FULL: begin
        if (!wake && (pd_rise || idle_expire)) begin
          pwr_d = aso ? PWR_PARTIAL : PWR_OFF;
        end
      end
      PWR_PARTIAL: begin
        if (wake) begin
          pwr_d = PWR_FULL;
        end else if (!aso) begin
          pwr_d = PWR_OFF;
        end
      end
      PWR_OFF: begin
        if (wake) begin
          pwr_d = PWR_FULL;
        end else if (aso) begin
          pwr_d = PWR_PARTIAL;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pwr_q            <= PWR_FULL;
      POWER_STATE      <= PWR_FULL;
      OSCILLATOR_RUN   <= 1'b1;
      ANALOG_POWER_ON  <= 1'b1;
      DIGITAL_POWER_ON <= 1'b1;
      SYNTH_DAC_MUTE   <= 1'b0;
      PIN_KEEPER_EN    <= 1'b0;
      PIN_PULLDOWN_EN  <= 1'b1;
    end else begin
      pwr_q            <= pwr_d;
      POWER_STATE      <= pwr_d;
      OSCILLATOR_RUN   <= pwr_d != PWR_OFF;
      ANALOG_POWER_ON  <= pwr_d != PWR_OFF;
      DIGITAL_POWER_ON <= pwr_d == PWR_FULL;
      SYNTH_DAC_MUTE   <= pwr_d != PWR_FULL;
      PIN_KEEPER_EN    <= pwr_d != PWR_FULL;
      PIN_PULLDOWN_EN  <= pwr_d == PWR_FULL;
    end
  end

  // analog output hold-off; the count pauses in partial power and clears in full
  // power-down, so a partial power-down taken too early leaves the outputs disabled
  logic [22:0] hold_q;
  logic        aout_ok_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_q             <= 23'h0;
      aout_ok_q          <= 1'b0;
      ANALOG_LINE_OUT_EN <= 1'b0;
    end else begin
      if (pwr_d == PWR_OFF) begin
        hold_q    <= 23'h0;
        aout_ok_q <= 1'b0;
      end else if (pwr_d == PWR_FULL && !aout_ok_q) begin
        if (hold_q == 23'(HOLD_CYCLES - 1)) begin
          aout_ok_q <= 1'b1;
        end else begin
          hold_q <= hold_q + 23'h1;
        end
      end
      ANALOG_LINE_OUT_EN <= aout_ok_q && pwr_d != PWR_OFF;
    end
  end

  // activity flags; a status read sets them and wins over a clear
  logic [2:0] act_q, act_clr;

  assign act_clr[0] = dma_evt
                    | (acc_evt & ((addr_q & PORT_PAIR_MSK) == PORT_CODEC))
                    | (wr_evt & is_status)
                    | (rd_evt & (addr_q == PORT_DSP_READ))
                    | (wr_evt & (addr_q == PORT_DSP_CMD));
  assign act_clr[1] = rd_evt & ((addr_q == PORT_DSP_CMD) | (addr_q == PORT_DSP_ACK));
  assign act_clr[2] = acc_evt & (((addr_q & PORT_PAIR_MSK) == PORT_SYNTH)
                    | in_fm | in_music);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      act_q <= ACT_RESET;
    end else if (rd_evt && is_status) begin
      act_q <= ACT_RESET;
    end else begin
      act_q <= act_q & ~act_clr;
    end
  end

  // host read data, driven while the read strobe stays low
  logic [7:0] status_byte;

  assign status_byte = {act_q,
                        se_pin | MIXER_SERIAL_EN | EXT_SYNTH_ACTIVE,
                        pwr_q == PWR_FULL,
                        MIDI_CMD_ACTIVE,
                        st_q};

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IO_DATA_OUT <= 8'h00;
      IO_DATA_OE  <= 1'b0;
    end else if (rd_evt && (is_status || is_pm)) begin
      IO_DATA_OUT <= is_status ? status_byte : pm_q;
      IO_DATA_OE  <= 1'b1;
    end else if (pin_q[0]) begin
      IO_DATA_OE  <= 1'b0;
    end
  end

  // request outputs hold their level while the digital section sleeps
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      DMA_REQUEST_OUT       <= 1'b0;
      INTERRUPT_REQUEST_OUT <= 1'b0;
    end else if (pwr_q == PWR_FULL && pwr_d == PWR_FULL) begin
      DMA_REQUEST_OUT       <= CORE_DMA_REQ;
      INTERRUPT_REQUEST_OUT <= CORE_IRQ;
    end
  end

  // programmed levels pass through unchanged in every power state
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      GENERAL_OUTPUT_ZERO <= PM_RESET[PM_GENERAL_OUTPUT_ZERO];
      GENERAL_OUTPUT_ONE  <= PM_RESET[PM_GENERAL_OUTPUT_ONE];
      SOFT_RESET_OUT      <= 1'b0;
      FIFO_RESET_OUT      <= 1'b0;
      SYNTH_RESET_OUT     <= 1'b0;
      SUSPEND_REQ_OUT     <= 1'b0;
    end else begin
      GENERAL_OUTPUT_ZERO <= pm_q[PM_GENERAL_OUTPUT_ZERO];
      GENERAL_OUTPUT_ONE  <= pm_q[PM_GENERAL_OUTPUT_ONE];
      SOFT_RESET_OUT      <= st_q[ST_SW_RESET];
      FIFO_RESET_OUT      <= st_q[ST_FIFO_RESET];
      SYNTH_RESET_OUT     <= pm_q[PM_SYNTH_RST];
      SUSPEND_REQ_OUT     <= pm_q[PM_SUSPEND];
    end
  end

  pd_partial_a: assert property (@(posedge CLK) disable iff (!NRST)
    pwr_q == PWR_FULL && pd_rise && aso && !wake |=> pwr_q == PWR_PARTIAL && SYNTH_DAC_MUTE)
    else $error("power-down request with analog on did not reach partial");
  osc_stop_a: assert property (@(posedge CLK) disable iff (!NRST)
    pwr_q == PWR_OFF |-> !OSCILLATOR_RUN && !ANALOG_POWER_ON)
    else $error("oscillator or analog running in full power-down");
  aout_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
    $past(pwr_q) == PWR_OFF && pwr_q == PWR_FULL |-> !ANALOG_LINE_OUT_EN [*8])
    else $error("analog outputs enabled too soon after full power-down");
  vol_wake_a: assert property (@(posedge CLK) disable iff (!NRST)
    pwr_q != PWR_FULL && vol_low |=> pwr_q == PWR_FULL ##1 DIGITAL_POWER_ON)
    else $error("volume button did not wake the device");
  io_wake_a: assert property (@(posedge CLK) disable iff (!NRST)
    pwr_q != PWR_FULL && dev_wake |=> pwr_q == PWR_FULL)
    else $error("port access did not wake the device");
  dma_wake_a: assert property (@(posedge CLK) disable iff (!NRST)
    pwr_q != PWR_FULL && dma_evt |=> pwr_q == PWR_FULL && !act_q[0])
    else $error("dma cycle did not wake or clear flag 0");
  flags_set_a: assert property (@(posedge CLK) disable iff (!NRST)
    rd_evt && is_status |=> act_q == 3'h7 ##1 IO_DATA_OE)
    else $error("status read did not set activity flags");
  flag1_clr_a: assert property (@(posedge CLK) disable iff (!NRST)
    rd_evt && addr_q == PORT_DSP_ACK |=> !act_q[1])
    else $error("read of acknowledge port left flag 1 set");
  irq_frozen_a: assert property (@(posedge CLK) disable iff (!NRST)
    pwr_q != PWR_FULL && $past(pwr_q) != PWR_FULL |=> $stable(INTERRUPT_REQUEST_OUT))
    else $error("interrupt request changed while powered down");

endmodule

// [sim/pdwam_host.sv]
/*
  Host processor model: drives the I/O port bus and the DMA acknowledge.
  Assumes it shares CLK with the monitor; strobes are levels held for
  several clocks, since the monitor synchronises them.
*/
module pdwam_host (
  input  wire logic        clk,
  output logic      [11:0] io_addr,
  output logic             io_read_n,
  output logic             io_write_n,
  output logic      [7:0]  io_data_in,
  input  wire logic [7:0]  io_data_out,
  input  wire logic        io_data_oe,
  output logic             dma_ack_n
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_addr    = 12'h000;
    io_read_n  = 1'b1;
    io_write_n = 1'b1;
    io_data_in = 8'h00;
    dma_ack_n  = 1'b1;
  end

  // one access; q is unknown when the monitor did not answer
  task automatic io_cycle(input logic wr, input logic [11:0] a, input logic [7:0] d,
                          output logic [7:0] q);
    @(posedge clk);
    io_addr    <= a;
    io_data_in <= d;
    @(posedge clk);
    if (wr)
      io_write_n <= 1'b0;
    else
      io_read_n <= 1'b0;
    repeat (7) @(posedge clk);
    q = (io_data_oe === 1'b1) ? io_data_out : 8'hXX;
    io_write_n <= 1'b1;
    io_read_n  <= 1'b1;
    repeat (4) @(posedge clk);
    // released lines flip so a stale value can never look valid
    io_addr    <= ~a;
    io_data_in <= ~d;
    repeat (2) @(posedge clk);
  endtask

  task automatic dma_cycle();
    @(posedge clk);
    dma_ack_n <= 1'b0;
    repeat (6) @(posedge clk);
    dma_ack_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
endmodule

// [sim/pdwam_monitor_test.sv]
/*
  Self-checking bench of the power-down and wake-up monitor.
  Assumes the host model in pdwam_host and shortened hold and unit counts.
*/
module pdwam_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pdwam_pkg::*;

  localparam int HOLD = 20;

  logic        clk;
  logic        nrst;
  logic [11:0] addr;
  logic        rd_n, wr_n, oe, dack_n, midi, cmd_idle, cdrq, cirq;
  logic [7:0]  din, dout, idle_units, q, pins;
  logic [2:0]  btn_n, ser_src;
  logic        drq, irq, general_output_zero, general_output_one, srst, frst, synrst, susp;
  logic        osc, apwr, dpwr, mute, line_en, keep, pulld;
  pdwam_pwr_t  state;
  int          mismatches = 0;
  int          checks_done = 0;
  int          cycles = 0;

  assign pins = {osc, apwr, dpwr, mute, keep, pulld, line_en, general_output_one};

  pdwam_monitor #(.HOLD_CYCLES(HOLD), .UNIT_CYCLES(10), .MUSIC_BASE(PORT_MUSIC_DEF))
    pdwam_monitor_inst (
    .CLK(clk), .NRST(nrst), .IO_ADDR(addr), .IO_READ_N(rd_n), .IO_WRITE_N(wr_n),
    .IO_DATA_IN(din), .IO_DATA_OUT(dout), .IO_DATA_OE(oe), .DMA_ACK_N(dack_n),
    .VOLUME_UP_BUTTON_N(btn_n[0]), .VOLUME_DOWN_BUTTON_N(btn_n[1]), .MUTE_BUTTON_N(btn_n[2]),
    .SERIAL_DSP_ENABLE_IN(ser_src[0]), .MIXER_SERIAL_EN(ser_src[1]),
    .EXT_SYNTH_ACTIVE(ser_src[2]), .MIDI_CMD_ACTIVE(midi), .CMD_IDLE(cmd_idle),
    .IDLE_UNITS(idle_units), .CORE_DMA_REQ(cdrq), .CORE_IRQ(cirq),
    .DMA_REQUEST_OUT(drq), .INTERRUPT_REQUEST_OUT(irq), .GENERAL_OUTPUT_ZERO(general_output_zero),
    .GENERAL_OUTPUT_ONE(general_output_one), .SOFT_RESET_OUT(srst), .FIFO_RESET_OUT(frst),
    .SYNTH_RESET_OUT(synrst), .SUSPEND_REQ_OUT(susp),
    .OSCILLATOR_RUN(osc), .ANALOG_POWER_ON(apwr),
    .DIGITAL_POWER_ON(dpwr), .SYNTH_DAC_MUTE(mute), .ANALOG_LINE_OUT_EN(line_en),
    .PIN_KEEPER_EN(keep), .PIN_PULLDOWN_EN(pulld), .POWER_STATE(state)
  );

  pdwam_host pdwam_host_inst (
    .clk(clk), .io_addr(addr), .io_read_n(rd_n), .io_write_n(wr_n), .io_data_in(din),
    .io_data_out(dout), .io_data_oe(oe), .dma_ack_n(dack_n)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // a hang cuts the run short and counts against it
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      results();
    end
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    pdwam_host_inst.io_cycle(1'b1, a, d, r);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] r;
    pdwam_host_inst.io_cycle(1'b0, a, 8'h00, r);
    check("read data", exp, r);
  endtask

  // op 0 reads, 1 writes, 2 runs a DMA cycle; then the status port shows the flags
  task automatic flag_case(input int op, input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] r;
    if (op == 2)
      pdwam_host_inst.dma_cycle();
    else
      pdwam_host_inst.io_cycle(op[0], a, 8'h00, r);
    rdchk(PORT_STATUS, exp);
  endtask

  task automatic wait_state(input pdwam_pwr_t s);
    for (int n = 0; n < 40 && state !== s; n++)
      @(posedge clk);
    check("power state", {6'h0, s}, {6'h0, state});
  endtask

  // analog-on is written before the request pulse and kept afterwards
  task automatic pwr_down(input logic an);
    wr(PORT_PWR_MGMT, {4'h0, an, 3'b010});
    wr(PORT_PWR_MGMT, {4'h0, an, 3'b110});
    wr(PORT_PWR_MGMT, {4'h0, an, 3'b010});
  endtask

  initial begin
    nrst = 1'b0;
    btn_n = 3'b111;
    ser_src = 3'b000;
    midi = 1'b0;
    cmd_idle = 1'b0;
    idle_units = 8'h00;
    cdrq = 1'b0;
    cirq = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("pins", 8'hE5, pins);
    rdchk(PORT_PWR_MGMT, 8'h02);
    rdchk(PORT_STATUS, 8'hE8);
    check("pins", 8'hE7, pins);
    done("reset");
    flag_case(2, 12'h000, 8'hC8);
    flag_case(0, PORT_CODEC, 8'hC8);
    flag_case(1, 12'h223, 8'hC8);
    flag_case(1, PORT_STATUS, 8'hC8);
    flag_case(0, PORT_DSP_READ, 8'hC8);
    flag_case(1, PORT_DSP_CMD, 8'hC8);
    flag_case(0, PORT_DSP_CMD, 8'hA8);
    flag_case(0, PORT_DSP_ACK, 8'hA8);
    flag_case(0, PORT_SYNTH, 8'h68);
    flag_case(1, 12'h229, 8'h68);
    flag_case(0, PORT_LEGACY_FM, 8'h68);
    flag_case(1, 12'h389, 8'h68);
    flag_case(0, PORT_MUSIC_DEF, 8'h68);
    flag_case(1, 12'h331, 8'h68);
    flag_case(0, PORT_PWR_MGMT, 8'hE8);
    done("flags");
    midi <= 1'b1;
    wr(PORT_STATUS, 8'h03);
    check("reset pins", 8'h03, {6'h0, frst, srst});
    rdchk(PORT_STATUS, 8'hCF);
    for (int i = 0; i < 3; i++) begin
      ser_src <= 3'b001 << i;
      rdchk(PORT_STATUS, 8'hFF);
    end
    ser_src <= 3'b000;
    midi <= 1'b0;
    wr(PORT_STATUS, 8'h00);
    // reserved bits 4 and 6 of the power management port read back low
    wr(PORT_PWR_MGMT, 8'hF3);
    rdchk(PORT_PWR_MGMT, 8'hA3);
    check("pm outputs", 8'h07, {5'h0, susp, synrst, general_output_zero});
    wr(PORT_PWR_MGMT, 8'h02);
    check("pm outputs", 8'h00, {5'h0, susp, synrst, general_output_zero});
    done("status");
    cdrq <= 1'b1;
    pwr_down(1'b1);
    wait_state(PWR_PARTIAL);
    cdrq <= 1'b0;
    cirq <= 1'b1;
    repeat (4) @(posedge clk);
    check("pins", 8'hDB, pins);
    check("requests", 8'h02, {5'h0, general_output_zero, drq, irq});
    rdchk(PORT_STATUS, 8'hC0);
    // analog power follows analog-on while the digital section sleeps
    wr(PORT_PWR_MGMT, 8'h02);
    wait_state(PWR_OFF);
    check("pins", 8'h19, pins);
    wr(PORT_PWR_MGMT, 8'h0A);
    wait_state(PWR_PARTIAL);
    check("pins", 8'hD9, pins);
    check("requests", 8'h02, {5'h0, general_output_zero, drq, irq});
    rdchk(PORT_DSP_READ, 8'hXX);
    wait_state(PWR_FULL);
    repeat (2) @(posedge clk);
    check("requests", 8'h01, {5'h0, general_output_zero, drq, irq});
    done("partial");
    for (int i = 0; i < 6; i++) begin
      pwr_down(1'b0);
      wait_state(PWR_OFF);
      check("pins", 8'h19, pins);
      rdchk(PORT_PWR_MGMT, 8'h02);
      check("power state", {6'h0, PWR_OFF}, {6'h0, state});
      if (i < 3) begin
        btn_n <= ~(3'b001 << i);
        repeat (6) @(posedge clk);
        btn_n <= 3'b111;
      end else if (i == 3)
        pdwam_host_inst.dma_cycle();
      else if (i == 4)
        pdwam_host_inst.io_cycle(1'b0, PORT_DSP_CMD, 8'h00, q);
      else
        wr(PORT_STATUS, 8'h01);
      wait_state(PWR_FULL);
      check("pins", 8'hE5, pins);
      repeat (HOLD + 4) @(posedge clk);
      check("pins", 8'hE7, pins);
    end
    wr(PORT_STATUS, 8'h00);
    done("wake");
    cmd_idle <= 1'b1;
    idle_units <= 8'h01;
    wait_state(PWR_OFF);
    idle_units <= 8'h00;
    pdwam_host_inst.io_cycle(1'b0, PORT_DSP_ACK, 8'h00, q);
    wait_state(PWR_FULL);
    done("self timed");
    pwr_down(1'b0);
    wait_state(PWR_OFF);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    check("pins", 8'hE5, pins);
    nrst <= 1'b1;
    rdchk(PORT_PWR_MGMT, 8'h02);
    done("hardware reset");
    results();
  end
endmodule
